// >>> hdl/dac_load_pkg.sv
// What this block does
// - Parallel port answers only while select low
// - Serial mode: select pin frames serial clocks
// - I2C mode: select and write pins are straps
// - Parallel write on write rising edge, select low
// - Write pin high in SPI: daisy chain on
// - Parallel data twelve bits, bit 11 MSB
// - Channel address picks one input channel
// - Register select picks input, offset, gain, special
// - Serial out shifts on rising serial clock
// - Toggle mode: bank pin picks register A/B
// - Two data registers; toggle load swaps them
// - Normal mode writes go to register A
// - Busy low while computing; parallel writes queued meanwhile
// - Load falling while busy high loads now
// - Load while busy low is held, done later
// - Power-on reset: busy low, interface off, loads ignored
// - Clear edge loads clear code, busy 35 us
// - Reset edge restarts power-on sequence, 270 us
// - Busy low through reset, high when done
// - After reset only next falling edge counts
// - SPI samples data on falling serial clock
// - Queue enable sampled at power-up, clear, reset
`default_nettype none
package dac_load_pkg;
   localparam int CH_NUM = 40;
   localparam int DATA_W = 12;
   localparam int ADDR_W = 5;
   localparam int CLK_MHZ = 25;
   localparam int CLEAR_US = 35;
   localparam int CLEAR_CYC = CLEAR_US * CLK_MHZ;
   localparam int RESET_US = 270;
   localparam int RESET_CYC = RESET_US * CLK_MHZ;
   localparam int CALC_CYC = 4;
   localparam int QUEUE_DEPTH = 16;
   localparam int SER_BITS = 24;
   localparam int SER_BANK_POS = 19;
   localparam int SER_ADDR_POS = 14;
   localparam int SER_REG_POS = 12;
   localparam logic [1:0] REG_SFR = 2'h0;
   localparam logic [1:0] REG_GAIN = 2'h1;
   localparam logic [1:0] REG_OFFS = 2'h2;
   localparam logic [1:0] REG_INPUT = 2'h3;
   localparam logic [4:0] SFR_CTRL = 5'h00;
   localparam logic [4:0] SFR_CLRCODE = 5'h01;
   localparam int CTRL_TOGGLE_POS = 0;
   localparam logic [11:0] INPUT_RST = 12'h000;
   localparam logic [11:0] GAIN_RST = 12'hFFF;
   localparam logic [11:0] OFFS_RST = 12'h800;
   localparam logic [11:0] CLRCODE_RST = 12'h000;
   localparam logic [11:0] MID_CODE = 12'h800;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CALC = 2'b01,
      ST_CLR = 2'b10,
      ST_RST = 2'b11
   } seq_e;
   typedef struct packed {
      logic bank;
      logic [4:0] addr;
      logic [1:0] sel;
      logic [11:0] data;
   } wr_s;
endpackage
`default_nettype wire

// >>> hdl/pin_sync.sv
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic [WIDTH-1:0] pins,
   output logic [WIDTH-1:0] synced,
   output logic [WIDTH-1:0] prev
);
   logic [WIDTH-1:0] meta_r;
   // Two stages per pin, third stage for edge detection
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock) begin
         meta_r[i] <= pins[i];
         synced[i] <= meta_r[i];
         prev[i] <= synced[i];
      end
   end
endmodule
`default_nettype wire

// >>> hdl/write_queue.sv
`default_nettype none
module write_queue
   import dac_load_pkg::*;
#(
   parameter int DEPTH = QUEUE_DEPTH
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic flush,
   input wire logic pushValid,
   output logic pushReady,
   input wire wr_s pushData,
   output logic popValid,
   input wire logic popReady,
   output wr_s popData
);
   localparam int PW = $clog2(DEPTH);
   wr_s mem [DEPTH];
   logic [PW-1:0] wrPtr_r;
   logic [PW-1:0] rdPtr_r;
   logic [PW:0] count_r;
   logic doPush;
   logic doPop;
   // Honest full and empty from the fill count
   assign pushReady = count_r != (PW+1)'(DEPTH);
   assign popValid = count_r != '0;
   assign popData = mem[rdPtr_r];
   assign doPush = pushValid && pushReady;
   assign doPop = popValid && popReady;
   // Storage
   always_ff @(posedge clock) begin
      if (doPush) begin
         mem[wrPtr_r] <= pushData;
      end
   end
   // Pointers and fill count
   always_ff @(posedge clock) begin
      if (sys_rst || flush) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         if (doPush) begin
            wrPtr_r <= wrPtr_r + 1'b1;
         end
         if (doPop) begin
            rdPtr_r <= rdPtr_r + 1'b1;
         end
         count_r <= count_r + (PW+1)'(doPush) - (PW+1)'(doPop);
      end
   end
endmodule
`default_nettype wire

// >>> hdl/dac_load_ctrl.sv
`default_nettype none
module dac_load_ctrl
   import dac_load_pkg::*;
#(
   parameter int RESET_CYCLES = RESET_CYC,
   parameter int DEPTH = QUEUE_DEPTH
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic iface_select,
   input wire logic spiI2cSel,
   input wire logic devSelN,
   input wire logic writePin,
   input wire logic [4:0] channel_addr,
   input wire logic [1:0] reg_select,
   input wire logic [11:0] parallel_data,
   input wire logic bankSel,
   input wire logic load_outputs_n,
   input wire logic clear_n,
   input wire logic resetPinN,
   input wire logic queueEnable,
   input wire logic [5:0] monChannel,
   output logic busy,
   output logic serial_out,
   output logic serialOutEn,
   output logic chain_enable,
   output logic addr_strap_0,
   output logic addr_strap_1,
   output logic toggleMode,
   output logic [11:0] monCode
);
   localparam int PINS = 28;
   logic [PINS-1:0] pinS;
   logic [PINS-1:0] pinP;
   logic serS, spiS, csS, wrS, ldS, clrS, rstS, qenS, bankS;
   logic csP, wrP, ldP, clrP, rstP, sclkS, sclkP, dinS;
   logic [1:0] selS;
   logic [4:0] addrS;
   logic [11:0] dataS;
   seq_e state_r;
   logic [15:0] cnt_r;
   logic queueOn_r, loadPend_r, toggle_r;
   logic [11:0] clearCode_r;
   logic [11:0] inA [CH_NUM];
   logic [11:0] inB [CH_NUM];
   logic [11:0] gain [CH_NUM];
   logic [11:0] offs [CH_NUM];
   logic [11:0] dac [CH_NUM];
   logic [CH_NUM-1:0] abSel_r;
   logic [SER_BITS-1:0] shiftIn_r;
   logic [5:0] bitCnt_r;
   logic serOut_r, chain_r, strap0_r, strap1_r;
   logic [11:0] monCode_r;
   logic parMode, spiMode, i2cMode, ifaceOn;
   logic pWrite, sWrite, newV, pushV, pushRdy, popV, direct, apply;
   logic ldFall, clrFall, rstFall, loadNow, seqEnd;
   wr_s pWr, sWr, newWr, popWr, applyWr;

   // All pins but monChannel cross into the clock domain first
   pin_sync #(.WIDTH(PINS)) u_sync (
      .clock(clock),
      .pins({iface_select, spiI2cSel, devSelN, writePin, load_outputs_n, clear_n,
         resetPinN, queueEnable, bankSel, reg_select, channel_addr, parallel_data}),
      .synced(pinS),
      .prev(pinP)
   );
   assign {serS, spiS, csS, wrS, ldS, clrS, rstS, qenS, bankS, selS, addrS, dataS} = pinS;
   assign {csP, wrP, ldP, clrP, rstP} = {pinP[25:24], pinP[23:21]};
   assign sclkS = dataS[10];
   assign sclkP = pinP[10];
   assign dinS = dataS[11];

   // Mode decode
   assign parMode = !serS;
   assign spiMode = serS && !spiS;
   assign i2cMode = serS && spiS;
   assign ifaceOn = state_r != ST_RST;

   // Falling edges of load, clear and reset pins
   assign ldFall = ldP && !ldS;
   assign clrFall = clrP && !clrS;
   assign rstFall = rstP && !rstS;

   // Parallel write on rising write strobe with select low
   assign pWrite = ifaceOn && parMode && !csS && !wrP && wrS;
   assign pWr = '{bank: bankS, addr: addrS, sel: selS, data: dataS};

   // Serial frame ends on select rising with full word
   assign sWrite = ifaceOn && spiMode && !csP && csS && bitCnt_r == 6'(SER_BITS);
   assign sWr = '{bank: shiftIn_r[SER_BANK_POS], addr: shiftIn_r[SER_ADDR_POS +: ADDR_W],
      sel: shiftIn_r[SER_REG_POS +: 2], data: shiftIn_r[DATA_W-1:0]};

   // Write source and queue steering
   assign newV = pWrite || sWrite;
   assign newWr = pWrite ? pWr : sWr;
   assign pushV = newV && queueOn_r && parMode && (state_r != ST_IDLE || popV);
   assign direct = newV && !pushV;
   assign apply = direct || (state_r == ST_IDLE && popV);
   assign applyWr = direct ? newWr : popWr;

   write_queue #(.DEPTH(DEPTH)) u_queue (
      .clock(clock),
      .sys_rst(sys_rst),
      .flush(state_r == ST_RST),
      .pushValid(pushV),
      .pushReady(pushRdy),
      .pushData(newWr),
      .popValid(popV),
      .popReady(state_r == ST_IDLE && !direct),
      .popData(popWr)
   );

   // Busy high only when idle with queue drained
   assign busy = state_r == ST_IDLE && !popV;
   assign loadNow = ifaceOn && busy && (ldFall || loadPend_r);
   assign seqEnd = cnt_r == 16'h0001;

   // Computed code from input, gain and offset
   function automatic logic [11:0] calcCode(input logic [11:0] x, input logic [11:0] m,
      input logic [11:0] c);
      logic [24:0] prod;
      logic signed [14:0] sum;
      prod = {13'h0000, x} * {12'h000, 13'({1'b0, m}) + 13'h0001};
      sum = $signed({3'h0, prod[23:12]}) + $signed({3'h0, c}) - $signed({3'h0, MID_CODE});
      if (sum < 0) begin
         return 12'h000;
      end else if (sum > $signed({3'h0, 12'hFFF})) begin
         return 12'hFFF;
      end
      return sum[11:0];
   endfunction

   // Sequencer: reset, clear and compute windows
   always_ff @(posedge clock) begin
      if (sys_rst || rstFall) begin
         state_r <= ST_RST;
         cnt_r <= 16'(RESET_CYCLES);
      end else if (clrFall && ifaceOn) begin
         state_r <= ST_CLR;
         cnt_r <= 16'(CLEAR_CYC);
      end else if (state_r != ST_IDLE && seqEnd) begin
         state_r <= ST_IDLE;
         cnt_r <= '0;
      end else if (apply) begin
         state_r <= (state_r == ST_CLR) ? ST_CLR : ST_CALC;
         cnt_r <= (state_r == ST_CLR) ? cnt_r - 1'b1 : 16'(CALC_CYC);
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   // Queue enable sampled as each reset or clear ends
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         queueOn_r <= 1'b0;
      end else if ((state_r == ST_RST || state_r == ST_CLR) && seqEnd) begin
         queueOn_r <= qenS;
      end
   end

   // Held load request
   always_ff @(posedge clock) begin
      if (sys_rst || state_r == ST_RST) begin
         loadPend_r <= 1'b0;
      end else if (loadNow) begin
         loadPend_r <= 1'b0;
      end else if (ldFall && !busy) begin
         loadPend_r <= 1'b1;
      end
   end

   // Register file writes, loads, clear and defaults
   always_ff @(posedge clock) begin
      if (sys_rst || state_r == ST_RST) begin
         toggle_r <= 1'b0;
         clearCode_r <= CLRCODE_RST;
         abSel_r <= '0;
         for (int i = 0; i < CH_NUM; i++) begin
            inA[i] <= INPUT_RST;
            inB[i] <= INPUT_RST;
            gain[i] <= GAIN_RST;
            offs[i] <= OFFS_RST;
            dac[i] <= calcCode(INPUT_RST, GAIN_RST, OFFS_RST);
         end
      end else begin
         if (apply) begin
            case (applyWr.sel)
               REG_SFR: begin
                  if (applyWr.addr == SFR_CTRL) begin
                     toggle_r <= applyWr.data[CTRL_TOGGLE_POS];
                  end else if (applyWr.addr == SFR_CLRCODE) begin
                     clearCode_r <= applyWr.data;
                  end
               end
               REG_GAIN: begin
                  gain[applyWr.addr] <= applyWr.data;
               end
               REG_OFFS: begin
                  offs[applyWr.addr] <= applyWr.data;
               end
               REG_INPUT: begin
                  if (toggle_r && applyWr.bank) begin
                     inB[applyWr.addr] <= applyWr.data;
                  end else begin
                     inA[applyWr.addr] <= applyWr.data;
                  end
               end
               default: begin
               end
            endcase
         end
         if (clrFall) begin
            for (int i = 0; i < CH_NUM; i++) begin
               dac[i] <= clearCode_r;
            end
         end else if (loadNow) begin
            for (int i = 0; i < CH_NUM; i++) begin
               dac[i] <= calcCode(abSel_r[i] ? inB[i] : inA[i], gain[i], offs[i]);
               abSel_r[i] <= toggle_r && !abSel_r[i];
            end
         end
      end
   end

   // SPI shift in on falling clock, out on rising
   always_ff @(posedge clock) begin
      if (sys_rst || csS || !spiMode) begin
         bitCnt_r <= '0;
         if (sys_rst) begin
            shiftIn_r <= '0;
            serOut_r <= 1'b0;
         end
      end else if (sclkP && !sclkS) begin
         shiftIn_r <= {shiftIn_r[SER_BITS-2:0], dinS};
         bitCnt_r <= (bitCnt_r == 6'(SER_BITS)) ? bitCnt_r : bitCnt_r + 1'b1;
      end else if (!sclkP && sclkS) begin
         serOut_r <= shiftIn_r[SER_BITS-1];
      end
   end

   // Chain enable, address straps and monitored code
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         chain_r <= 1'b0;
         strap0_r <= 1'b0;
         strap1_r <= 1'b0;
         monCode_r <= '0;
      end else begin
         chain_r <= spiMode && wrS;
         if (i2cMode) begin
            strap0_r <= csS;
            strap1_r <= wrS;
         end
         monCode_r <= (monChannel < 6'(CH_NUM)) ? dac[monChannel] : 12'h000;
      end
   end
   assign serial_out = serOut_r;
   assign serialOutEn = chain_r && !csS;
   assign chain_enable = chain_r;
   assign addr_strap_0 = strap0_r;
   assign addr_strap_1 = strap1_r;
   assign toggleMode = toggle_r;
   assign monCode = monCode_r;

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence s_clrStart;
      clrFall && ifaceOn && !rstFall ##1 state_r == ST_CLR;
   endsequence
   sequence s_heldLoad;
      ldFall && !busy && ifaceOn && !rstFall ##1 loadPend_r;
   endsequence
   chk_reset_busy: assert property (state_r == ST_RST |-> !busy)
      else $error("busy high during reset sequence");
   chk_reset_start: assert property (rstFall |=> state_r == ST_RST && !busy)
      else $error("reset edge did not start sequence");
   chk_clear_len: assert property (s_clrStart |-> (!busy)[*8])
      else $error("clear window too short");
   chk_clear_end: assert property (state_r == ST_CLR && cnt_r == 16'h0001 && !rstFall
      |=> state_r == ST_IDLE)
      else $error("clear window did not end on count");
   chk_load_held: assert property (s_heldLoad |-> ##[0:1000] !loadPend_r)
      else $error("held load not served");
   chk_load_toggle: assert property (loadNow && toggle_r && !clrFall
      |=> abSel_r[0] != $past(abSel_r[0]))
      else $error("toggle load did not swap bank");
   chk_write_select: assert property (pWrite && !pushV && pWr.sel == REG_INPUT && !toggle_r
      |=> inA[$past(pWr.addr)] == $past(pWr.data))
      else $error("selected parallel write did not land");
   chk_queue_busy: assert property (popV && state_r == ST_IDLE && !rstFall && !clrFall
      |=> state_r == ST_CALC)
      else $error("queued write not applied when idle");
   chk_ignore_reset: assert property (state_r == ST_RST && !seqEnd |=> !loadPend_r)
      else $error("load held during reset");
endmodule
`default_nettype wire

// >>> tb/host_model.sv
`default_nettype none
module host_model (
   input wire logic clock,
   output logic iface_select,
   output logic spiI2cSel,
   output logic devSelN,
   output logic writePin,
   output logic [4:0] channel_addr,
   output logic [1:0] reg_select,
   output logic [11:0] parallel_data,
   output logic bankSel,
   output logic load_outputs_n
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle host: parallel mode, deselected, write strobe low, load strobe high
   initial begin
      iface_select = 1'b0;
      spiI2cSel = 1'b0;
      devSelN = 1'b1;
      writePin = 1'b0;
      channel_addr = 5'h00;
      reg_select = 2'h0;
      parallel_data = 12'h000;
      bankSel = 1'b0;
      load_outputs_n = 1'b1;
   end

   // Pins move one small delay after the edge
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // Parallel write; each level held past the pin synchronisers
   task automatic par_write(input logic selN, input logic bank, input logic [4:0] a,
                            input logic [1:0] s, input logic [11:0] d);
      channel_addr = a;
      reg_select = s;
      parallel_data = d;
      bankSel = bank;
      devSelN = selN;
      step(4);
      writePin = 1'b1;
      step(4);
      writePin = 1'b0;
      step(4);
      devSelN = 1'b1;
      parallel_data = ~d; // Released bus shows no stale word
      step(4);
   endtask

   // Serial frame, MSB first, data taken on falling serial clock
   task automatic spi_frame(input logic [23:0] f);
      parallel_data[10] = 1'b1;
      devSelN = 1'b0;
      step(4);
      for (int i = 23; i >= 0; i--) begin
         parallel_data[11] = f[i];
         step(4);
         parallel_data[10] = 1'b0;
         step(4);
         parallel_data[10] = 1'b1;
      end
      step(4);
      devSelN = 1'b1;
      parallel_data[11] = ~f[0];
      step(8);
   endtask

   // Load strobe
   task automatic load_pulse();
      load_outputs_n = 1'b0;
      step(4);
      load_outputs_n = 1'b1;
      step(4);
   endtask

   // Interface mode and strap levels
   task automatic set_mode(input logic ser, input logic i2c, input logic selN, input logic wr);
      iface_select = ser;
      spiI2cSel = i2c;
      devSelN = selN;
      writePin = wr;
      step(8);
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`default_nettype none
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin mismatches++; \
   $display("ERROR %0t ns: value mismatch", $time); end end
module tb_top;
   import dac_load_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RST_CYC = 20;
   logic clock, sys_rst, clear_n, resetPinN, queueEnable;
   logic iface_select, spiI2cSel, devSelN, writePin, bankSel, load_outputs_n;
   logic [4:0] channel_addr;
   logic [1:0] reg_select;
   logic [11:0] parallel_data, monCode, v1, v2;
   logic [5:0] monChannel;
   logic busy, serial_out, serialOutEn, chain_enable, addr_strap_0, addr_strap_1, toggleMode;
   int mismatches = 0;
   int nTests = 0;
   int lowCnt = 0;
   int base;

   dac_load_ctrl #(.RESET_CYCLES(RST_CYC), .DEPTH(QUEUE_DEPTH)) dut_u (
      .clock(clock),
      .sys_rst(sys_rst),
      .iface_select(iface_select),
      .spiI2cSel(spiI2cSel),
      .devSelN(devSelN),
      .writePin(writePin),
      .channel_addr(channel_addr),
      .reg_select(reg_select),
      .parallel_data(parallel_data),
      .bankSel(bankSel),
      .load_outputs_n(load_outputs_n),
      .clear_n(clear_n),
      .resetPinN(resetPinN),
      .queueEnable(queueEnable),
      .monChannel(monChannel),
      .busy(busy),
      .serial_out(serial_out),
      .serialOutEn(serialOutEn),
      .chain_enable(chain_enable),
      .addr_strap_0(addr_strap_0),
      .addr_strap_1(addr_strap_1),
      .toggleMode(toggleMode),
      .monCode(monCode)
   );
   host_model host_u (
      .clock(clock),
      .iface_select(iface_select),
      .spiI2cSel(spiI2cSel),
      .devSelN(devSelN),
      .writePin(writePin),
      .channel_addr(channel_addr),
      .reg_select(reg_select),
      .parallel_data(parallel_data),
      .bankSel(bankSel),
      .load_outputs_n(load_outputs_n)
   );

   // Clock, 40 ns period
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Cycles with busy not high
   always @(posedge clock) if (busy !== 1'b1) lowCnt++;

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", nTests, mismatches);
      if (mismatches == 0 && nTests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Bounded wait for idle
   task automatic wait_idle();
      int i;
      for (i = 0; i < 2000 && busy !== 1'b1; i++) host_u.step(1);
      `CHK(busy, 1'b1)
   endtask

   task automatic read_code(input logic [5:0] ch, output logic [11:0] v);
      monChannel = ch;
      host_u.step(3);
      v = monCode;
   endtask

   task automatic load_wait();
      host_u.load_pulse();
      wait_idle();
      host_u.step(4);
   endtask

   // Power-on style start: busy low for the reset count
   task automatic scn_start();
      host_u.step(6);
      sys_rst = 1'b0;
      base = lowCnt;
      wait_idle();
      `CHK((lowCnt - base) inside {[RST_CYC:RST_CYC + 6]}, 1'b1)
   endtask

   // Input, gain and offset writes, load, channel read back
   task automatic scn_parallel();
      base = lowCnt;
      host_u.par_write(1'b0, 1'b1, 5'd5, REG_INPUT, 12'h400);
      `CHK(lowCnt > base, 1'b1)
      host_u.par_write(1'b0, 1'b0, 5'd5, REG_GAIN, 12'h7ff);
      host_u.par_write(1'b0, 1'b0, 5'd5, REG_OFFS, 12'h900);
      load_wait();
      read_code(6'd5, v1);
      `CHK(v1, 12'h300)
      read_code(6'd45, v1);
      `CHK(v1, 12'h000)
   endtask

   // Deselected write is ignored
   task automatic scn_select();
      host_u.par_write(1'b1, 1'b0, 5'd6, REG_INPUT, 12'habc);
      load_wait();
      read_code(6'd6, v1);
      `CHK(v1, 12'h000)
   endtask

   // Load arriving during the compute window is held
   task automatic scn_held_load();
      fork
         host_u.par_write(1'b0, 1'b0, 5'd7, REG_INPUT, 12'h3c3);
         begin
            host_u.step(6);
            host_u.load_pulse();
         end
      join
      wait_idle();
      host_u.step(4);
      read_code(6'd7, v1);
      `CHK(v1, 12'h3c3)
   endtask

   // Toggle mode alternates the two banks per load
   task automatic scn_toggle();
      host_u.par_write(1'b0, 1'b0, SFR_CTRL, REG_SFR, 12'h001);
      wait_idle();
      `CHK(toggleMode, 1'b1)
      host_u.par_write(1'b0, 1'b0, 5'd2, REG_INPUT, 12'h111);
      host_u.par_write(1'b0, 1'b1, 5'd2, REG_INPUT, 12'h222);
      load_wait();
      read_code(6'd2, v1);
      load_wait();
      read_code(6'd2, v2);
      `CHK(v1, 12'h111)
      `CHK(v2, 12'h222)
      host_u.par_write(1'b0, 1'b0, SFR_CTRL, REG_SFR, 12'h000);
      wait_idle();
      `CHK(toggleMode, 1'b0)
   endtask

   // Serial frame, chain enable and strap capture
   task automatic scn_serial();
      host_u.set_mode(1'b1, 1'b0, 1'b1, 1'b0);
      host_u.spi_frame(24'h82_76d2);
      wait_idle();
      `CHK(serial_out, 1'b1)
      host_u.set_mode(1'b1, 1'b0, 1'b0, 1'b1);
      `CHK(chain_enable, 1'b1)
      `CHK(serialOutEn, 1'b1)
      host_u.set_mode(1'b1, 1'b1, 1'b0, 1'b1);
      `CHK({addr_strap_1, addr_strap_0}, 2'b10)
      `CHK(serialOutEn, 1'b0)
      host_u.set_mode(1'b1, 1'b1, 1'b1, 1'b0);
      host_u.set_mode(1'b0, 1'b0, 1'b1, 1'b0);
      load_wait();
      read_code(6'd9, v1);
      `CHK(v1, 12'h6d2)
   endtask

   // Clear edge: every channel to the clear code, busy low for its span
   task automatic scn_clear();
      host_u.par_write(1'b0, 1'b0, SFR_CLRCODE, REG_SFR, 12'h5a5);
      wait_idle();
      base = lowCnt;
      clear_n = 1'b0;
      host_u.step(6);
      host_u.par_write(1'b0, 1'b0, 5'd8, REG_INPUT, 12'h123);
      wait_idle();
      `CHK((lowCnt - base) inside {[CLEAR_CYC + 4:CLEAR_CYC + 6]}, 1'b1)
      read_code(6'd5, v1);
      `CHK(v1, 12'h5a5)
      read_code(6'd8, v1);
      `CHK(v1, 12'h5a5)
      clear_n = 1'b1;
      host_u.step(4);
      load_wait();
      read_code(6'd8, v1);
      `CHK(v1, 12'h123)
   endtask

   // Queue off after reset: write in clear window applies at once
   task automatic scn_queue_off();
      base = lowCnt;
      clear_n = 1'b0;
      host_u.step(6);
      host_u.par_write(1'b0, 1'b0, 5'd8, REG_INPUT, 12'h0f0);
      wait_idle();
      `CHK((lowCnt - base) inside {[CLEAR_CYC - 1:CLEAR_CYC + 1]}, 1'b1)
      clear_n = 1'b1;
      host_u.step(4);
      load_wait();
      read_code(6'd8, v1);
      `CHK(v1, 12'h0f0)
   endtask

   // Reset pin edge restores defaults; held low level is ignored
   task automatic scn_reset_pin();
      queueEnable = 1'b0;
      host_u.step(4);
      base = lowCnt;
      resetPinN = 1'b0;
      host_u.step(6);
      wait_idle();
      `CHK((lowCnt - base) inside {[RST_CYC - 1:RST_CYC + 2]}, 1'b1)
      host_u.step(30);
      `CHK(busy, 1'b1)
      load_wait();
      read_code(6'd5, v1);
      `CHK(v1, 12'h000)
      resetPinN = 1'b1;
   endtask

   // Main sequence
   initial begin
      sys_rst = 1'b1;
      clear_n = 1'b1;
      resetPinN = 1'b1;
      queueEnable = 1'b1;
      monChannel = 6'd0;
      scn_start();
      scn_parallel();
      scn_select();
      scn_held_load();
      scn_toggle();
      scn_serial();
      scn_clear();
      scn_reset_pin();
      scn_queue_off();
      complete_run();
   end

   // Watchdog
   initial begin
      repeat (20000) @(posedge clock);
      mismatches++;
      complete_run();
   end
endmodule
`default_nettype wire
